// *** rtl/sinc_filter_rate_settle_control.sv ***
// Sinc decimation, output rate, chop and settling control with full-scale coefficients
`timescale 1ns/1ps
`default_nettype none
`include "sinc_defs.svh"
// Notes on behaviour
// - Four readable writable 24-bit full-scale coefficients
// - Coefficients start factory value, replaced by cal/write
// - Order bit clear fourth order, set third
// - Unchopped period is 1024 times rate word
// - Unchopped settling is order output periods
// - Chop: settle, invert input, settle, average
// - Chopped period is order times 1024 times rate
// - Chopped settling equals two output periods
// - Dual notch adds 60 Hz notch at 50
// - Zero latency waits full settling per result
// - Zero latency rate independent of channel count
// - Swap bit clear no chop, set chops
// - Channel select resets filter, clears ready, settles
module sinc_filter_rate_settle_control
  import sinc_pkg::*;
(
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               arst_n,
  // Register port
  input  wire logic [`ADDR_W-1:0] reg_addr,
  input  wire logic [`REG_W-1:0]  reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic [`REG_W-1:0]       reg_rdata,
  // Modulator bitstream, one sample per master clock tick
  input  wire logic               mod_valid,
  input  wire logic               mod_bit,
  output logic                    swap_polarity,
  output logic                    filter_reset,
  // Channel sequencer and calibration links
  input  wire logic               chan_select,
  input  wire logic [1:0]         chan_pair,
  input  wire logic               cal_fs_load,
  input  wire logic [1:0]         cal_fs_pair,
  input  wire logic [`REG_W-1:0]  cal_fs_value,
  input  wire logic [3:0][23:0]   factory_fs,
  // Result side
  output logic                    data_ready,
  output logic                    result_strobe,
  output logic                    result_valid,
  input  wire logic               result_ready,
  output logic [`REG_W-1:0]       result_data
);
  stream_if #(.W(`REG_W)) fill_s ();
  stream_if #(.W(`REG_W)) drain_s ();

  word_t      mode_q;
  word_t      fs_q [4];
  logic       loaded_q;
  word_t      last_q;
  logic       ready_q;
  logic       overrun_q;
  logic       strobe_q;
  logic       pend_q;
  word_t      pend_data_q;
  logic [1:0] pair_q;
  seq_state_t state_q;
  logic       swap_q;
  logic       have_prev_q;
  word_t      prev_q;
  logic       rst_pulse_q;
  acc_t       integ_q [4];
  acc_t       dly_q [4];
  acc_t       notch_q;
  cnt_t       cnt_q;
  logic [2:0] tick_cnt_q;

  logic [9:0] rate;
  logic       order3;
  logic       notch_en;
  logic       zlat_en;
  logic       swap_en;
  logic       run_en;
  logic [2:0] order;
  cnt_t       period;
  cnt_t       notch_pt;
  logic       tick;
  logic       phase_done;
  logic       restart;
  logic       res_fire;
  logic       fs_sel;
  logic [1:0] fs_idx;
  acc_t       top;
  acc_t       comb [4];
  acc_t       final_v;
  acc_t       filt_v;
  acc_t       shifted;
  acc_t       in_val;
  logic [6:0] shamt;
  word_t      phase_word;
  word_t      avg_word;
  word_t      raw_word;
  logic [47:0] prod;
  word_t      res_word;

  function automatic logic [3:0] clog2_rate(input logic [9:0] r);
    logic [3:0] b;
    b = '0;
    for (int i = 0; i < 10; i++) begin
      if (r > 10'((1 << i) - 1)) begin
        b = 4'(i + 1);
      end
    end
    return b;
  endfunction

  // Mode fields
  assign rate     = mode_q[`MODE_RATE_LSB +: `MODE_RATE_W];
  assign order3   = mode_q[`MODE_ORDER_BIT];
  assign order    = order3 ? `ORDER_LO : `ORDER_HI;
  assign notch_en = mode_q[`MODE_NOTCH_BIT];
  assign zlat_en  = mode_q[`MODE_ZLAT_BIT];
  assign swap_en  = mode_q[`MODE_SWAP_BIT];
  assign run_en   = mode_q[`MODE_RUN_BIT];
  // One decimated word every 1024 x rate word master ticks; rate 0 is never programmed
  assign period   = cnt_t'({rate, {`DEC_BASE_SHIFT{1'b0}}});
  assign notch_pt = cnt_t'((32'(period) * `NOTCH_NUM) / `NOTCH_DEN);

  // Register decode
  assign fs_sel = (reg_addr >= `REG_FS_BASE) && (reg_addr <= `REG_FS_LAST);
  assign fs_idx = reg_addr[1:0];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= `MODE_RESET;
    end else if (reg_wr && reg_addr == `REG_MODE) begin
      mode_q <= reg_wdata;
    end
  end

  // Factory trim is taken once after reset release; calibration wins over a write
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      loaded_q <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        fs_q[i] <= `FS_COEF_RESET;
      end
    end else if (!loaded_q) begin
      loaded_q <= 1'b1;
      for (int i = 0; i < 4; i++) begin
        fs_q[i] <= factory_fs[i];
      end
    end else if (cal_fs_load) begin
      fs_q[cal_fs_pair] <= cal_fs_value;
    end else if (reg_wr && fs_sel) begin
      fs_q[fs_idx] <= reg_wdata;
    end
  end

  // Read data one cycle after the strobe, zero elsewhere and on unmapped addresses
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      if (fs_sel) begin
        reg_rdata <= fs_q[fs_idx];
      end else begin
        case (reg_addr)
          `REG_MODE:   reg_rdata <= mode_q;
          `REG_STATUS: reg_rdata <= word_t'({pair_q, pend_q, overrun_q, swap_q,
                                             (state_q == ST_RUN), ready_q});
          `REG_DATA:   reg_rdata <= last_q;
          default:     reg_rdata <= '0;
        endcase
      end
    end else begin
      reg_rdata <= '0;
    end
  end

  // Filter restart causes
  assign tick       = mod_valid && (cnt_q == period - 1'b1) && (state_q != ST_IDLE);
  assign phase_done = tick && (tick_cnt_q == order - 1'b1);

  always_comb begin
    restart = 1'b0;
    if (state_q == ST_IDLE && run_en) begin
      restart = 1'b1;
    end
    if (chan_select && run_en) begin
      restart = 1'b1;
    end
    if (state_q != ST_IDLE && (swap_en || zlat_en) && phase_done) begin
      restart = 1'b1;
    end
  end

  // Result events
  always_comb begin
    res_fire = 1'b0;
    if (state_q != ST_IDLE && !chan_select) begin
      if (swap_en) begin
        res_fire = phase_done && have_prev_q;
      end else if (zlat_en) begin
        res_fire = phase_done;
      end else begin
        res_fire = tick && (tick_cnt_q >= order - 1'b1);
      end
    end
  end

  // Integrators: modulator bit becomes +/-1, inverted in the swapped half
  assign in_val = (mod_bit ^ swap_q) ? acc_t'(1) : '1;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 4; i++) begin
        integ_q[i] <= '0;
      end
    end else if (restart) begin
      for (int i = 0; i < 4; i++) begin
        integ_q[i] <= '0;
      end
    end else if (mod_valid && state_q != ST_IDLE) begin
      integ_q[0] <= integ_q[0] + in_val;
      for (int i = 1; i < 4; i++) begin
        integ_q[i] <= integ_q[i] + integ_q[i-1];
      end
    end
  end

  // Comb chain in the decimated domain; order 3 taps the third integrator
  always_comb begin
    top     = order3 ? integ_q[2] : integ_q[3];
    comb[0] = top - dly_q[0];
    for (int i = 1; i < 4; i++) begin
      comb[i] = comb[i-1] - dly_q[i];
    end
    final_v = order3 ? comb[2] : comb[3];
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 4; i++) begin
        dly_q[i] <= '0;
      end
    end else if (restart) begin
      for (int i = 0; i < 4; i++) begin
        dly_q[i] <= '0;
      end
    end else if (tick) begin
      dly_q[0] <= top;
      for (int i = 1; i < 4; i++) begin
        dly_q[i] <= comb[i-1];
      end
    end
  end

  // Second look at the filter 5/6 into the period puts a notch at 6/5 of the rate
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      notch_q <= '0;
    end else if (restart) begin
      notch_q <= '0;
    end else if (mod_valid && cnt_q == notch_pt) begin
      notch_q <= final_v;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q      <= '0;
      tick_cnt_q <= '0;
    end else if (restart) begin
      cnt_q      <= '0;
      tick_cnt_q <= '0;
    end else if (mod_valid && state_q != ST_IDLE) begin
      cnt_q <= tick ? '0 : cnt_q + 1'b1;
      if (tick && tick_cnt_q != `ORDER_HI) begin
        tick_cnt_q <= tick_cnt_q + 1'b1;
      end
    end
  end

  // Scaling to a 24-bit word and applying the full-scale coefficient
  always_comb begin
    filt_v     = notch_en ? {final_v[`INT_W-1], final_v[`INT_W-1:1]} +
                            {notch_q[`INT_W-1], notch_q[`INT_W-1:1]} : final_v;
    shamt      = 7'(order * (`DEC_BASE_SHIFT + clog2_rate(rate))) - 7'd23;
    shifted    = $signed(filt_v) >>> shamt;
    phase_word = shifted[`REG_W-1:0];
    avg_word   = word_t'(($signed({prev_q[`REG_W-1], prev_q}) +
                          $signed({phase_word[`REG_W-1], phase_word})) >>> 1);
    raw_word   = swap_en ? avg_word : phase_word;
  end

  assign prod     = 48'($signed({{24{raw_word[`REG_W-1]}}, raw_word}) *
                        $signed({24'h000000, fs_q[pair_q]}));
  assign res_word = prod[`FS_GAIN_SHIFT +: `REG_W];

  // Chop phase bookkeeping
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      swap_q      <= 1'b0;
      have_prev_q <= 1'b0;
      prev_q      <= '0;
    end else if (!swap_en || state_q == ST_IDLE || chan_select) begin
      swap_q      <= 1'b0;
      have_prev_q <= 1'b0;
    end else if (phase_done) begin
      swap_q      <= ~swap_q;
      prev_q      <= phase_word;
      have_prev_q <= !(zlat_en && have_prev_q);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_IDLE;
      pair_q  <= '0;
    end else begin
      if (chan_select) begin
        pair_q <= chan_pair;
      end
      case (state_q)
        ST_IDLE:   state_q <= run_en ? ST_SETTLE : ST_IDLE;
        ST_SETTLE: begin
          if (!run_en) begin
            state_q <= ST_IDLE;
          end else if (res_fire) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (!run_en) begin
            state_q <= ST_IDLE;
          end else if (chan_select) begin
            state_q <= ST_SETTLE;
          end
        end
        default:   state_q <= ST_IDLE;
      endcase
    end
  end

  // Ready flag: a new result wins over a data read; a channel change blocks the result and clears the flag
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ready_q <= 1'b0;
      last_q  <= '0;
    end else if (res_fire) begin
      ready_q <= 1'b1;
      last_q  <= res_word;
    end else if (chan_select || (reg_rd && reg_addr == `REG_DATA)) begin
      ready_q <= 1'b0;
    end
  end

  // One-word holding stage ahead of the buffer; back-pressure raises overrun
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pend_q      <= 1'b0;
      pend_data_q <= '0;
      overrun_q   <= 1'b0;
    end else begin
      if (res_fire) begin
        pend_q      <= 1'b1;
        pend_data_q <= res_word;
      end else if (fill_s.ready) begin
        pend_q <= 1'b0;
      end
      if (res_fire && pend_q && !fill_s.ready) begin
        overrun_q <= 1'b1;
      end else if (reg_wr && reg_addr == `REG_STATUS) begin
        overrun_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      strobe_q    <= 1'b0;
      rst_pulse_q <= 1'b0;
    end else begin
      strobe_q    <= res_fire;
      rst_pulse_q <= restart;
    end
  end

  assign fill_s.valid  = pend_q;
  assign fill_s.data   = pend_data_q;
  assign drain_s.ready = result_ready;
  assign result_valid  = drain_s.valid;
  assign result_data   = drain_s.data;
  assign data_ready    = ready_q;
  assign result_strobe = strobe_q;
  assign filter_reset  = rst_pulse_q;
  assign swap_polarity = swap_q;

  sinc_fifo #(
    .W  (`REG_W),
    .D  (`FIFO_DEPTH),
    .AW (`FIFO_AW)
  ) u_fifo (
    .clk    (clk),
    .arst_n (arst_n),
    .wr     (fill_s),
    .rd     (drain_s)
  );
endmodule
`default_nettype wire

// *** inc/sinc_defs.svh ***
// Register map, field positions, reset values and timing counts of the decimation control
`ifndef SINC_DEFS_SVH
`define SINC_DEFS_SVH
`define ADDR_W           4
`define REG_W            24
`define REG_MODE         4'h0
`define REG_STATUS       4'h1
`define REG_DATA         4'h2
`define REG_FS_BASE      4'h4
`define REG_FS_LAST      4'h7
`define MODE_RATE_LSB    0
`define MODE_RATE_W      10
`define MODE_ZLAT_BIT    11
`define MODE_NOTCH_BIT   13
`define MODE_ORDER_BIT   15
`define MODE_RUN_BIT     20
`define MODE_SWAP_BIT    23
`define MODE_RESET       24'h000060
`define FS_COEF_RESET    24'h500000
`define DEC_BASE_SHIFT   10
`define CNT_W            20
`define INT_W            84
`define ORDER_HI         3'h4
`define ORDER_LO         3'h3
`define NOTCH_NUM        5
`define NOTCH_DEN        6
`define FS_GAIN_SHIFT    22
`define FIFO_DEPTH       16
`define FIFO_AW          4
`endif

// *** inc/sinc_pkg.sv ***
// Types shared by the decimation control and its testbench
`include "sinc_defs.svh"
package sinc_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_SETTLE, ST_RUN} seq_state_t;
  typedef logic [`REG_W-1:0]  word_t;
  typedef logic [`INT_W-1:0]  acc_t;
  typedef logic [`CNT_W-1:0]  cnt_t;
endpackage

// *** inc/stream_if.sv ***
// Valid/ready word stream between the control block and its result buffer
`timescale 1ns/1ps
`default_nettype none
interface stream_if #(parameter int W = 24);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport tx (output valid, output data, input ready);
  modport rx (input valid, input data, output ready);
endinterface
`default_nettype wire

// *** rtl/sinc_fifo.sv ***
// Parameterised result buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sinc_fifo #(
  parameter int W  = 24,
  parameter int D  = 16,
  parameter int AW = 4
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // Filling side
  stream_if.rx      wr,
  // Draining side
  stream_if.tx      rd
);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  assign wr.ready = (cnt_q != (AW+1)'(D));
  assign rd.valid = (cnt_q != '0);
  assign rd.data  = mem[rp_q];
  assign push     = wr.valid && wr.ready;
  assign pop      = rd.valid && rd.ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_q] <= wr.data;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == AW'(D-1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == AW'(D-1)) ? '0 : rp_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// *** verif/sinc_ctl_sva.sv ***
// Port assertions for the decimation control
`timescale 1ns/1ps
`default_nettype none
`include "sinc_defs.svh"
module sinc_ctl_sva (
  // Clock and reset
  input wire logic               clk,
  input wire logic               arst_n,
  // Register port
  input wire logic [`ADDR_W-1:0] reg_addr,
  input wire logic               reg_rd,
  input wire logic [`REG_W-1:0]  reg_rdata,
  // Control and result side
  input wire logic               chan_select,
  input wire logic               filter_reset,
  input wire logic               data_ready,
  input wire logic               result_strobe,
  input wire logic               result_valid,
  input wire logic               result_ready,
  input wire logic [`REG_W-1:0]  result_data
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic [15:0] gap_q;
  logic [15:0] cs_q;
  // Cycles since the last result and since the last channel change, saturating
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gap_q <= '0;
      cs_q  <= 16'hffff;
    end else begin
      gap_q <= result_strobe ? 16'h0 : gap_q + {15'h0, gap_q != 16'hffff};
      cs_q  <= chan_select ? 16'h0 : cs_q + {15'h0, cs_q != 16'hffff};
    end
  end
  property p_rd_idle; !reg_rd |=> reg_rdata == '0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
  property p_rd_hole; reg_rd && (reg_addr == 4'h3 || reg_addr > 4'h7) |=> reg_rdata == '0; endproperty
  a_rd_hole: assert property (p_rd_hole) else $error("unmapped read not zero");
  property p_stb_pulse; result_strobe |=> !result_strobe; endproperty
  a_stb_pulse: assert property (p_stb_pulse) else $error("strobe too long");
  property p_stb_rdy; result_strobe |-> data_ready; endproperty
  a_stb_rdy: assert property (p_stb_rdy) else $error("strobe without ready");
  property p_stb_val; result_strobe |=> result_valid; endproperty
  a_stb_val: assert property (p_stb_val) else $error("result not queued");
  property p_hold; result_valid && !result_ready |=> result_valid && $stable(result_data); endproperty
  a_hold: assert property (p_hold) else $error("result dropped");
  property p_cs_rdy; chan_select |=> !data_ready; endproperty
  a_cs_rdy: assert property (p_cs_rdy) else $error("ready kept");
  property p_cs_rst; chan_select |=> filter_reset ##1 !filter_reset [*8]; endproperty
  a_cs_rst: assert property (p_cs_rst) else $error("no filter reset");
  property p_gap; result_strobe |-> gap_q >= 16'd1023; endproperty
  a_gap: assert property (p_gap) else $error("results too close");
  property p_settle; result_strobe |-> cs_q >= 16'd3071; endproperty
  a_settle: assert property (p_settle) else $error("result before settling");
  c_result: cover property (result_strobe);
  c_chan: cover property (chan_select ##1 !data_ready);
  c_pop: cover property (result_valid && result_ready);
endmodule
`default_nettype wire

// *** verif/mod_model.sv ***
// Modulator bitstream model feeding the filter
`timescale 1ns/1ps
`default_nettype none
module mod_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // Pace and controls from the block
  input  wire logic slow,
  input  wire logic swap_polarity,
  input  wire logic filter_reset,
  // Bitstream
  output logic      mod_valid,
  output logic      mod_bit
);
  logic [7:0] lfsr_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lfsr_q    <= 8'h5a;
      mod_valid <= 1'b0;
      mod_bit   <= 1'b0;
    end else begin
      // Slow pace ticks every other cycle; the bit flips between ticks
      mod_valid <= slow ? !mod_valid : 1'b1;
      lfsr_q    <= filter_reset ? 8'h5a : {lfsr_q[6:0], ^(lfsr_q & 8'hb8)};
      mod_bit   <= (slow && mod_valid) ? !mod_bit : lfsr_q[0] ^ swap_polarity;
    end
  end
endmodule
`default_nettype wire

// *** verif/tb_sinc_filter_rate_settle_control.sv ***
// Self-checking bench for the decimation control
`timescale 1ns/1ps
`default_nettype none
`include "sinc_defs.svh"
module tb_sinc_filter_rate_settle_control
  import sinc_pkg::*;
;
  logic               clk = 1'b0;
  logic               arst_n = 1'b0;
  logic [`ADDR_W-1:0] reg_addr = '0;
  word_t              reg_wdata = '0;
  logic               reg_wr = 1'b0;
  logic               reg_rd = 1'b0;
  word_t              reg_rdata;
  logic               mod_valid, mod_bit, swap_polarity, filter_reset;
  logic               chan_select = 1'b0;
  logic [1:0]         chan_pair = '0;
  logic               cal_fs_load = 1'b0;
  logic [1:0]         cal_fs_pair = '0;
  word_t              cal_fs_value = '0;
  logic [3:0][23:0]   factory_fs = {24'h4f1e2d, 24'h50c3b4, 24'h4e8a71, 24'h5137c9};
  logic               data_ready, result_strobe, result_valid;
  logic               result_ready = 1'b0;
  word_t              result_data;
  logic               slow = 1'b0, hold = 1'b1, rd_d = 1'b0, sw_d = 1'b0;
  int                 err_total = 0, n_checks = 0, gap = 0, nstb = 0, pops = 0, swaps = 0;
  int                 lo_q[$], hi_q[$];
  word_t              ev_q[$], em_q[$], last_pop = '0;

  always #4 clk = ~clk;

  sinc_filter_rate_settle_control u_sinc_filter_rate_settle_control (
    .clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .mod_valid, .mod_bit, .swap_polarity, .filter_reset, .chan_select, .chan_pair,
    .cal_fs_load, .cal_fs_pair, .cal_fs_value, .factory_fs, .data_ready,
    .result_strobe, .result_valid, .result_ready, .result_data);
  mod_model u_mod_model (.clk, .arst_n, .slow, .swap_polarity, .filter_reset,
    .mod_valid, .mod_bit);

  task automatic chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input word_t d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input word_t e, input word_t m);
    ev_q.push_back(e);
    em_q.push_back(m);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  task automatic wait_n(input int n);
    int t;
    t = nstb + n;
    for (int k = 0; k < 40000 && nstb < t; k++) @(negedge clk);
    if (nstb < t) begin
      chk(1'b0, "result missing");
      wrap_up();
    end
  endtask
  // Expected spacing: settling first, then the output period, in clock cycles
  task automatic run_mode(input logic [2:0] i, input int n);
    int o, s, p, m, s0;
    word_t w;
    o = i[0] ? 3 : 4;
    s = (i[1] ? 2 * o : o) * 1024;
    p = i[2] ? s : (i[1] ? o : 1) * 1024;
    m = slow ? 2 : 1;
    s0 = swaps;
    lo_q.push_back(s * m);
    hi_q.push_back(s * m + 6 * m);
    repeat (n - 1) begin
      lo_q.push_back(p * m);
      hi_q.push_back(p * m);
    end
    w = {i[1], 3'h1, 4'h0, i[0], 1'b0, i[0] ^ i[1], 1'b0, i[2], 11'h1};
    wr(`REG_MODE, w);
    wait_n(n);
    wr(`REG_MODE, 24'h000001);
    // Let a stopped chop drop its swap level inside this mode's count
    repeat (3) @(negedge clk);
    chk((swaps != s0) === i[1], "swap activity");
    chk(lo_q.size() == 0, "results short");
    $display("mode %0d done", i);
  endtask

  always @(posedge clk) result_ready <= !hold && ($urandom_range(1) == 1);

  always @(posedge clk) begin
    rd_d <= reg_rd;
    sw_d <= swap_polarity;
    gap = (reg_wr || chan_select) ? 0 : gap + 1;
    if (swap_polarity !== sw_d) swaps++;
    if (result_valid && result_ready) begin
      pops++;
      last_pop = result_data;
    end
    if (rd_d) begin
      chk((reg_rdata & em_q[0]) === (ev_q[0] & em_q[0]), "read data");
      void'(ev_q.pop_front());
      void'(em_q.pop_front());
    end
    if (result_strobe) begin
      nstb++;
      chk(lo_q.size() > 0, "extra result");
      if (lo_q.size() > 0) begin
        chk(gap >= lo_q[0] && gap <= hi_q[0], "result spacing");
        void'(lo_q.pop_front());
        void'(hi_q.pop_front());
      end
      gap = 0;
    end
  end

  initial begin
    word_t v;
    int p0;
    void'($urandom(32'h576c));
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    rd(`REG_MODE, `MODE_RESET, 24'hffffff);
    for (int k = 0; k < 4; k++) rd(4'(`REG_FS_BASE + k), factory_fs[k], 24'hffffff);
    rd(4'h3, '0, 24'hffffff);
    rd(4'h9, '0, 24'hffffff);
    for (int k = 0; k < 4; k++) begin
      v = word_t'($urandom);
      wr(4'(`REG_FS_BASE + k), v);
      rd(4'(`REG_FS_BASE + k), v, 24'hffffff);
    end
    @(posedge clk);
    cal_fs_load <= 1'b1;
    cal_fs_pair <= 2'h2;
    cal_fs_value <= 24'h3c5a96;
    @(posedge clk);
    cal_fs_load <= 1'b0;
    rd(4'h6, 24'h3c5a96, 24'hffffff);
    $display("register test done");
    run_mode(3'b001, 18);
    rd(`REG_STATUS, 24'h000008, 24'h000008);
    @(posedge clk);
    hold <= 1'b0;
    p0 = pops;
    for (int k = 0; k < 300 && (pops - p0 < 17 || result_valid !== 1'b0); k++) @(negedge clk);
    chk(pops - p0 == 17, "buffered result count");
    if (pops - p0 != 17 || result_valid !== 1'b0) wrap_up();
    // The held word was overwritten, so the last one drained is the newest result
    chk(data_ready === 1'b1, "ready before data read");
    rd(`REG_DATA, last_pop, 24'hffffff);
    @(negedge clk);
    chk(data_ready === 1'b0, "ready after data read");
    wr(`REG_STATUS, 24'h000008);
    rd(`REG_STATUS, 24'h0, 24'h000008);
    $display("buffer test done");
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      slow = (i == 1);
      run_mode(i[2:0], i >= 6 ? 1 : 2);
    end
    lo_q.push_back(4096);
    hi_q.push_back(4102);
    lo_q.push_back(4096);
    hi_q.push_back(4102);
    wr(`REG_MODE, 24'h100001);
    wait_n(1);
    @(posedge clk);
    chan_select <= 1'b1;
    chan_pair <= 2'h1;
    @(posedge clk);
    chan_select <= 1'b0;
    @(negedge clk);
    chk(data_ready === 1'b0, "ready after channel change");
    wait_n(1);
    wr(`REG_MODE, 24'h000001);
    $display("channel change test done");
    wrap_up();
  end
endmodule

bind sinc_filter_rate_settle_control sinc_ctl_sva u_sinc_ctl_sva (
  .clk, .arst_n, .reg_addr, .reg_rd, .reg_rdata, .chan_select, .filter_reset,
  .data_ready, .result_strobe, .result_valid, .result_ready, .result_data);
`default_nettype wire
